// ---- rtl/csf_bitops.sv ----
// single-bit select, deposit and pick on one byte
// assumes sel and din are stable same-clock values
`timescale 1ns/1ns
`default_nettype none
module csf_bitops
(
  input wire logic [2:0] sel,
  input wire logic [7:0] din,
  input wire logic tin,
  output logic [7:0] mask,
  output logic [7:0] dep,
  output logic pick
);

  // ----------------------------------------------------------------
  // per-bit decode: mask and deposit of the carried-in bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      assign mask[i] = (sel == 3'(i));
      assign dep[i] = mask[i] ? tin : din[i];
    end
  endgenerate

  // chosen bit of the byte
  assign pick = din[sel];

endmodule
`default_nettype wire

// ---- rtl/csf_core.sv ----
// execution core for stores, program reads, I/O, stack, shifts, flags
// assumes an Avalon-MM master, same-clock data memory, program memory
// and I/O space; memory ready comes from the arbiter on core_clk
`timescale 1ns/1ns
`default_nettype none
`include "csf_params.svh"
module csf_core
  import csf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic dm_req,
  output logic dm_we,
  output logic [15:0] dm_addr,
  output logic [7:0] dm_wdata,
  input wire logic [7:0] dm_rdata,
  input wire logic dm_ready,
  output logic [14:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  output logic [5:0] io_addr,
  output logic io_we,
  output logic io_re,
  output logic io_set,
  output logic io_clr,
  output logic [7:0] io_wdata,
  output logic [7:0] io_mask,
  input wire logic [7:0] io_rdata,
  output logic brk_pulse,
  output logic sleep_pulse,
  output logic wdr_pulse
);

  csf_state_t state_ff, nxt_state;
  csf_op_t op_ff, nxt_op;
  logic [4:0] rd_ff, nxt_rd;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] pflags_ff, nxt_pflags;
  logic [7:0] pmbyte_ff, nxt_pmbyte;
  logic [7:0] flags_ff, nxt_flags;
  logic [7:0] cyc_ff, nxt_cyc;
  logic [15:0] sp_ff, nxt_sp;
  logic nvm_ff, nxt_nvm;
  logic xtra_ff, nxt_xtra;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] gpr_ff [32];
  logic [7:0] nxt_gpr [32];

  csf_op_t acc_op;
  logic [4:0] acc_rd;
  logic [7:0] acc_val;
  logic [5:0] acc_q;
  logic [15:0] yptr, zptr;
  logic instr_wr, is_store, mem_ok;
  logic [7:0] sh_out, sh_flags, bit_mask, bit_dep;
  logic bit_pick;

  // ----------------------------------------------------------------
  // instruction fields taken straight off the write data
  // ----------------------------------------------------------------
  assign acc_op = csf_op_t'(avs_writedata[`CSF_F_OP_LSB +: 6]);
  assign acc_rd = avs_writedata[`CSF_F_RD_LSB +: 5];
  assign acc_q = avs_writedata[`CSF_F_Q_LSB +: 6];
  assign acc_val = gpr_ff[acc_rd];
  assign yptr = {gpr_ff[`CSF_REG_YH], gpr_ff[`CSF_REG_YL]};
  assign zptr = {gpr_ff[`CSF_REG_ZH], gpr_ff[`CSF_REG_ZL]};
  assign instr_wr = avs_write && (avs_address == `CSF_OFS_INSTR);

  // operands are worked out at issue so the execute cycle only commits
  csf_shifter u_shift (
    .op(acc_op),
    .din(acc_val),
    .fin(flags_ff),
    .dout(sh_out),
    .fout(sh_flags)
  );

  csf_bitops u_bits (
    .sel(avs_writedata[`CSF_F_BIT_LSB +: 3]),
    .din(acc_val),
    .tin(flags_ff[`CSF_FLG_T]),
    .mask(bit_mask),
    .dep(bit_dep),
    .pick(bit_pick)
  );

  // ----------------------------------------------------------------
  // memory handshake; nonvolatile space never completes first cycle
  // ----------------------------------------------------------------
  assign is_store = (op_ff == OP_DISP_WR_Y) || (op_ff == OP_DISP_WR_Z) ||
                    (op_ff == OP_IND_WR) || (op_ff == OP_IND_WR_INC) ||
                    (op_ff == OP_IND_WR_DEC) || (op_ff == OP_PUSH);
  assign mem_ok = dm_ready && (!nvm_ff || xtra_ff);
  assign dm_req = ((state_ff == S_EXEC) && is_store) || (state_ff == S_WAIT);
  assign dm_we = is_store;
  assign dm_addr = addr_ff;
  assign dm_wdata = wdata_ff;
  assign pm_addr = addr_ff[15:1];

  // ----------------------------------------------------------------
  // I/O strobes and control pulses, all in the execute cycle
  // ----------------------------------------------------------------
  assign io_addr = addr_ff[5:0];
  assign io_wdata = wdata_ff;
  assign io_mask = mask_ff;
  assign io_re = (state_ff == S_EXEC) && (op_ff == OP_IO_RD);
  assign io_we = (state_ff == S_EXEC) && (op_ff == OP_IO_WR);
  assign io_set = (state_ff == S_EXEC) && (op_ff == OP_IO_SET);
  assign io_clr = (state_ff == S_EXEC) && (op_ff == OP_IO_CLR);
  assign brk_pulse = (state_ff == S_EXEC) && (op_ff == OP_BREAK);
  assign sleep_pulse = (state_ff == S_EXEC) && (op_ff == OP_SLEEP);
  assign wdr_pulse = (state_ff == S_EXEC) && (op_ff == OP_WDOG_KICK);

  // ----------------------------------------------------------------
  // bus answer: issue waits for completion, reads take one wait
  // ----------------------------------------------------------------
  assign avs_waitrequest = (instr_wr && (state_ff != S_DONE)) ||
                           (avs_read && !rvalid_ff);
  assign avs_readdata = rdata_ff;

  // ----------------------------------------------------------------
  // next state of sequencer, register file, flags and bus slave
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_rd = rd_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_mask = mask_ff;
    nxt_pflags = pflags_ff;
    nxt_pmbyte = pmbyte_ff;
    nxt_flags = flags_ff;
    nxt_cyc = cyc_ff;
    nxt_sp = sp_ff;
    nxt_nvm = nvm_ff;
    nxt_xtra = xtra_ff | dm_req;
    nxt_gpr = gpr_ff;
    nxt_rvalid = avs_read && !rvalid_ff;
    nxt_rdata = rdata_ff;
    // register reads; unmapped offsets answer zero
    if (avs_read && !rvalid_ff)
    begin
      nxt_rdata = 32'h0000_0000;
      if (avs_address[7])
        nxt_rdata = {24'h00_0000, gpr_ff[avs_address[6:2]]};
      else if (avs_address == `CSF_OFS_FLAGS)
        nxt_rdata = {24'h00_0000, flags_ff};
      else if (avs_address == `CSF_OFS_SP)
        nxt_rdata = {16'h0000, sp_ff};
      else if (avs_address == `CSF_OFS_STAT)
        nxt_rdata = {18'h0_0000, state_ff, cyc_ff};
    end
    // direct register writes only while no instruction runs
    if (avs_write && (state_ff == S_IDLE))
    begin
      if (avs_address[7] && avs_byteenable[0])
        nxt_gpr[avs_address[6:2]] = avs_writedata[7:0];
      else if ((avs_address == `CSF_OFS_FLAGS) && avs_byteenable[0])
        nxt_flags = avs_writedata[7:0];
      else if (avs_address == `CSF_OFS_SP)
      begin
        if (avs_byteenable[0])
          nxt_sp[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1])
          nxt_sp[15:8] = avs_writedata[15:8];
      end
    end
    case (state_ff)
      S_IDLE:
      begin
        nxt_xtra = 1'b0;
        if (instr_wr)
        begin
          nxt_state = S_EXEC;
          nxt_op = acc_op;
          nxt_rd = (acc_op == OP_PMR_DEF) ? 5'(`CSF_REG_ZERO) : acc_rd;
          nxt_cyc = 8'h00;
          nxt_wdata = acc_val;
          nxt_mask = bit_mask;
          nxt_pflags = sh_flags;
          nxt_addr = zptr;
          case (acc_op)
            OP_DISP_WR_Y: nxt_addr = yptr + {10'h000, acc_q};
            OP_DISP_WR_Z: nxt_addr = zptr + {10'h000, acc_q};
            OP_IND_WR_DEC: nxt_addr = zptr - 16'h0001;
            OP_PUSH: nxt_addr = sp_ff;
            OP_POP: nxt_addr = sp_ff + 16'h0001;
            OP_IO_RD, OP_IO_WR, OP_IO_SET, OP_IO_CLR: nxt_addr = {10'h000, acc_q};
            default: nxt_addr = zptr;
          endcase
          case (acc_op)
            OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_SAR: nxt_wdata = sh_out;
            OP_T_DEPOSIT: nxt_wdata = bit_dep;
            default: nxt_wdata = acc_val;
          endcase
          case (acc_op)
            OP_T_CAPTURE:
            begin
              nxt_pflags = flags_ff;
              nxt_pflags[`CSF_FLG_T] = bit_pick;
            end
            OP_FLAG_SET: nxt_pflags = flags_ff | bit_mask;
            OP_FLAG_CLR: nxt_pflags = flags_ff & ~bit_mask;
            default: nxt_pflags = sh_flags;
          endcase
          nxt_nvm = (nxt_addr >= `CSF_NVM_BASE);
        end
      end
      S_EXEC:
      begin
        nxt_cyc = cyc_ff + 8'h01;
        nxt_state = S_DONE;
        case (op_ff)
          OP_DISP_WR_Y, OP_DISP_WR_Z, OP_IND_WR, OP_IND_WR_INC, OP_IND_WR_DEC, OP_PUSH:
          begin
            if (!mem_ok)
              nxt_state = S_WAIT;
          end
          OP_POP: nxt_state = S_WAIT;
          OP_PMR_DEF, OP_PMR, OP_PMR_INC: nxt_state = S_PM2;
          OP_IO_RD: nxt_gpr[rd_ff] = io_rdata;
          OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_SAR:
          begin
            nxt_gpr[rd_ff] = wdata_ff;
            nxt_flags = pflags_ff;
          end
          OP_T_DEPOSIT: nxt_gpr[rd_ff] = wdata_ff;
          OP_T_CAPTURE, OP_FLAG_SET, OP_FLAG_CLR: nxt_flags = pflags_ff;
          default: nxt_state = S_DONE;
        endcase
      end
      S_WAIT:
      begin
        nxt_cyc = cyc_ff + 8'h01;
        if (mem_ok)
        begin
          nxt_state = S_DONE;
          if (op_ff == OP_POP)
          begin
            nxt_gpr[rd_ff] = dm_rdata;
            nxt_sp = addr_ff;
          end
        end
      end
      S_PM2:
      begin
        nxt_cyc = cyc_ff + 8'h01;
        nxt_pmbyte = addr_ff[0] ? pm_rdata[15:8] : pm_rdata[7:0];
        nxt_state = S_PM3;
      end
      S_PM3:
      begin
        nxt_cyc = cyc_ff + 8'h01;
        nxt_gpr[rd_ff] = pmbyte_ff;
        if (op_ff == OP_PMR_INC)
        begin
          nxt_gpr[`CSF_REG_ZL] = nxt_addr_inc(addr_ff, 1'b0);
          nxt_gpr[`CSF_REG_ZH] = nxt_addr_inc(addr_ff, 1'b1);
        end
        nxt_state = S_DONE;
      end
      S_DONE: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
    // pointer and stack updates when a store completes
    if (((state_ff == S_EXEC) || (state_ff == S_WAIT)) && is_store && mem_ok)
    begin
      if (op_ff == OP_IND_WR_INC)
      begin
        nxt_gpr[`CSF_REG_ZL] = nxt_addr_inc(addr_ff, 1'b0);
        nxt_gpr[`CSF_REG_ZH] = nxt_addr_inc(addr_ff, 1'b1);
      end
      else if (op_ff == OP_IND_WR_DEC)
      begin
        nxt_gpr[`CSF_REG_ZL] = addr_ff[7:0];
        nxt_gpr[`CSF_REG_ZH] = addr_ff[15:8];
      end
      else if (op_ff == OP_PUSH)
        nxt_sp = addr_ff - 16'h0001;
    end
  end

  // byte of pointer plus one
  function automatic logic [7:0] nxt_addr_inc(input logic [15:0] a, input logic hi);
    logic [15:0] s;
    s = a + 16'h0001;
    return hi ? s[15:8] : s[7:0];
  endfunction

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= S_IDLE;
      op_ff <= OP_NOP;
      rd_ff <= 5'h00;
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      mask_ff <= 8'h00;
      pflags_ff <= `CSF_FLAGS_RST;
      pmbyte_ff <= 8'h00;
      flags_ff <= `CSF_FLAGS_RST;
      cyc_ff <= 8'h00;
      sp_ff <= `CSF_SP_RST;
      nvm_ff <= 1'b0;
      xtra_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      for (int i = 0; i < 32; i++)
        gpr_ff[i] <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      rd_ff <= nxt_rd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      mask_ff <= nxt_mask;
      pflags_ff <= nxt_pflags;
      pmbyte_ff <= nxt_pmbyte;
      flags_ff <= nxt_flags;
      cyc_ff <= nxt_cyc;
      sp_ff <= nxt_sp;
      nvm_ff <= nxt_nvm;
      xtra_ff <= nxt_xtra;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      gpr_ff <= nxt_gpr;
    end
  end

  // ----------------------------------------------------------------
  // checks of timing and effects
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_pm_walk;
    (state_ff == S_EXEC) ##1 (state_ff == S_PM2) ##1 (state_ff == S_PM3) ##1 (state_ff == S_DONE);
  endsequence

  a_store_ram_one: assert property ((state_ff == S_EXEC) && is_store && dm_ready && !nvm_ff
    |=> (state_ff == S_DONE) && $stable(flags_ff)) else $error("ram store not one cycle");
  a_zinc_update: assert property ((state_ff == S_EXEC) && (op_ff == OP_IND_WR_INC) && mem_ok
    |=> zptr == $past(addr_ff) + 16'h0001) else $error("post-increment wrong");
  a_zdec_addr: assert property ((state_ff == S_IDLE) && instr_wr && (acc_op == OP_IND_WR_DEC)
    |=> dm_addr == $past(zptr) - 16'h0001) else $error("pre-decrement address wrong");
  a_pm_three: assert property ((state_ff == S_IDLE) && instr_wr &&
    ((acc_op == OP_PMR) || (acc_op == OP_PMR_DEF) || (acc_op == OP_PMR_INC))
    |=> s_pm_walk) else $error("program read not three cycles");
  a_io_single: assert property ((state_ff == S_EXEC) && (io_re || io_we)
    |=> (state_ff == S_DONE) && $stable(flags_ff)) else $error("io transfer wrong");
  a_pop_two: assert property ((state_ff == S_EXEC) && (op_ff == OP_POP)
    |=> (state_ff == S_WAIT) && dm_req && !dm_we) else $error("pop not in two cycles");
  a_shl_carry: assert property ((state_ff == S_EXEC) && (op_ff == OP_SHL)
    |=> flags_ff[`CSF_FLG_C] == $past(gpr_ff[rd_ff][7])) else $error("left carry wrong");
  a_shr_neg: assert property ((state_ff == S_EXEC) && (op_ff == OP_SHR)
    |=> !flags_ff[`CSF_FLG_N]) else $error("logical right shift sign");
  a_io_bit_mask: assert property ((io_set || io_clr) |-> $onehot(io_mask))
    else $error("bit mask not one-hot");
  a_flag_only: assert property ((state_ff == S_EXEC) && (op_ff == OP_FLAG_SET)
    |=> $onehot0(flags_ff ^ $past(flags_ff))) else $error("flag set touched others");
  a_nvm_extra: assert property ((state_ff == S_EXEC) && is_store && nvm_ff
    |=> state_ff == S_WAIT) else $error("nonvolatile access without extra cycle");
  a_stall_hold: assert property ((state_ff == S_WAIT) && !dm_ready
    |=> (state_ff == S_WAIT) && avs_waitrequest) else $error("stall released early");
  a_ctrl_one: assert property ((brk_pulse || sleep_pulse || wdr_pulse)
    |=> (state_ff == S_DONE) && $stable(flags_ff)) else $error("control pulse");

endmodule
`default_nettype wire

// ---- rtl/csf_params.svh ----
// constants of the store/shift/flag execution block
// assumes inclusion by bare name from the rtl folder
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the slave port)
// ----------------------------------------------------------------
`define CSF_OFS_INSTR 8'h00
`define CSF_OFS_FLAGS 8'h04
`define CSF_OFS_SP 8'h08
`define CSF_OFS_STAT 8'h0C
`define CSF_OFS_GPR 8'h80

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define CSF_F_OP_LSB 0
`define CSF_F_RD_LSB 8
`define CSF_F_BIT_LSB 16
`define CSF_F_Q_LSB 24

// ----------------------------------------------------------------
// flag positions in the flags register
// ----------------------------------------------------------------
`define CSF_FLG_C 0
`define CSF_FLG_Z 1
`define CSF_FLG_N 2
`define CSF_FLG_V 3
`define CSF_FLG_S 4
`define CSF_FLG_H 5
`define CSF_FLG_T 6
`define CSF_FLG_I 7

// ----------------------------------------------------------------
// register numbers, reset values, memory map
// ----------------------------------------------------------------
`define CSF_REG_ZERO 0
`define CSF_REG_YL 28
`define CSF_REG_YH 29
`define CSF_REG_ZL 30
`define CSF_REG_ZH 31
`define CSF_SP_RST 16'h0FFF
`define CSF_FLAGS_RST 8'h00
`define CSF_NVM_BASE 16'h4000

// ----------------------------------------------------------------
// cycle counts of the executing phase
// ----------------------------------------------------------------
`define CSF_CYC_ONE 8'h01
`define CSF_CYC_POP 8'h02
`define CSF_CYC_PMR 8'h03

`endif

// ---- rtl/csf_pkg.sv ----
// types shared by the store/shift/flag execution block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package csf_pkg;

  // ----------------------------------------------------------------
  // operation codes of the instruction word
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_DISP_WR_Y = 6'h01,
    OP_DISP_WR_Z = 6'h02,
    OP_IND_WR = 6'h03,
    OP_IND_WR_INC = 6'h04,
    OP_IND_WR_DEC = 6'h05,
    OP_PMR_DEF = 6'h06,
    OP_PMR = 6'h07,
    OP_PMR_INC = 6'h08,
    OP_IO_RD = 6'h09,
    OP_IO_WR = 6'h0A,
    OP_PUSH = 6'h0B,
    OP_POP = 6'h0C,
    OP_SHL = 6'h0D,
    OP_SHR = 6'h0E,
    OP_ROTL = 6'h0F,
    OP_ROTR = 6'h10,
    OP_SAR = 6'h11,
    OP_IO_SET = 6'h12,
    OP_IO_CLR = 6'h13,
    OP_T_CAPTURE = 6'h14,
    OP_T_DEPOSIT = 6'h15,
    OP_FLAG_SET = 6'h16,
    OP_FLAG_CLR = 6'h17,
    OP_BREAK = 6'h18,
    OP_SLEEP = 6'h19,
    OP_WDOG_KICK = 6'h1A
  } csf_op_t;

  // ----------------------------------------------------------------
  // execution sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_EXEC = 6'h02,
    S_WAIT = 6'h04,
    S_PM2 = 6'h08,
    S_PM3 = 6'h10,
    S_DONE = 6'h20
  } csf_state_t;

endpackage
`default_nettype wire

// ---- rtl/csf_shifter.sv ----
// shift and rotate unit: result byte and updated flags
// assumes op and operands come from same-clock logic
`timescale 1ns/1ns
`default_nettype none
`include "csf_params.svh"
module csf_shifter
  import csf_pkg::*;
(
  input wire csf_op_t op,
  input wire logic [7:0] din,
  input wire logic [7:0] fin,
  output logic [7:0] dout,
  output logic [7:0] fout
);

  logic cout;
  logic left;

  // ----------------------------------------------------------------
  // data path; carry always takes the bit shifted out
  // ----------------------------------------------------------------
  always_comb
  begin
    left = 1'b0;
    cout = din[0];
    case (op)
      OP_SHL:
      begin
        dout = {din[6:0], 1'b0};
        cout = din[7];
        left = 1'b1;
      end
      OP_ROTL:
      begin
        dout = {din[6:0], fin[`CSF_FLG_C]};
        cout = din[7];
        left = 1'b1;
      end
      OP_SHR: dout = {1'b0, din[7:1]};
      OP_ROTR: dout = {fin[`CSF_FLG_C], din[7:1]};
      OP_SAR: dout = {din[7], din[7:1]};
      default: dout = din;
    endcase
  end

  // ----------------------------------------------------------------
  // flags; sign flag is left alone, half carry only on left moves
  // ----------------------------------------------------------------
  always_comb
  begin
    fout = fin;
    fout[`CSF_FLG_C] = cout;
    fout[`CSF_FLG_Z] = (dout == 8'h00);
    fout[`CSF_FLG_N] = dout[7];
    fout[`CSF_FLG_V] = dout[7] ^ cout;
    if (left)
    begin
      fout[`CSF_FLG_H] = din[3];
    end
  end

endmodule
`default_nettype wire

// ---- verif/cpu_store_shift_flag_ops_tb.sv ----
// bench for csf_core: bus tasks, instruction runs, result checks
// assumes csf_mem_model as memory and a bench-made I/O space
`timescale 1ns/1ns
`default_nettype none
module cpu_store_shift_flag_ops_tb
  import csf_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, dm_req, dm_we, dm_ready, io_we, io_re, io_set, io_clr;
  logic brk_pulse, sleep_pulse, wdr_pulse;
  logic [15:0] dm_addr, pm_rdata;
  logic [7:0] dm_wdata, dm_rdata, io_wdata, io_mask, io_rdata;
  logic [14:0] pm_addr;
  logic [5:0] io_addr;
  logic [3:0] stall = 4'h0;
  logic [16:0] io_log = 17'h0;
  logic [2:0] ctl_log = 3'h0;
  int err_count = 0, total_checks = 0, cyc = 0;
  csf_op_t sh_op [5] = '{OP_SHL, OP_ROTL, OP_SHR, OP_ROTR, OP_SAR};
  logic [7:0] sh_res [5] = '{8'h02, 8'h03, 8'h40, 8'hC0, 8'hC0};
  logic [7:0] sh_flg [5] = '{8'h09, 8'h09, 8'h29, 8'h25, 8'h25};
  csf_op_t ct_op [4] = '{OP_NOP, OP_BREAK, OP_SLEEP, OP_WDOG_KICK};
  logic [2:0] ct_exp [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  csf_core dut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dm_req, .dm_we, .dm_addr,
    .dm_wdata, .dm_rdata, .dm_ready, .pm_addr, .pm_rdata, .io_addr, .io_we, .io_re,
    .io_set, .io_clr, .io_wdata, .io_mask, .io_rdata, .brk_pulse, .sleep_pulse,
    .wdr_pulse);
  csf_mem_model mdl (.core_clk, .dm_req, .dm_we, .dm_addr, .dm_wdata, .dm_rdata,
    .dm_ready, .pm_addr, .pm_rdata, .stall);
  // I/O space answers with a value tied to the address
  assign io_rdata = 8'h3C ^ {2'b00, io_addr};
  initial
    forever #5 core_clk = ~core_clk;
  // strobes last one cycle, so keep what they carried
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (io_we || io_set || io_clr)
      io_log <= {io_we, io_set, io_clr, io_addr, io_we ? io_wdata : io_mask};
    if (brk_pulse || sleep_pulse || wdr_pulse)
      ctl_log <= {brk_pulse, sleep_pulse, wdr_pulse};
    if (cyc == 5000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hFF);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask
  task automatic gr(input logic [4:0] n, input logic [7:0] v);
    bus(1'b1, {1'b1, n, 2'b00}, {24'h0, v});
  endtask
  task automatic rg(input string nm, input logic [4:0] n, input logic [7:0] e);
    rc(nm, {1'b1, n, 2'b00}, {24'h0, e});
  endtask
  // run one instruction; a nonzero n is the expected cycle count
  task automatic ex(input csf_op_t op, input logic [4:0] r, input logic [2:0] b,
    input logic [5:0] q, input logic [7:0] n);
    bus(1'b1, 8'h00, {2'b00, q, 5'h0, b, 3'h0, r, 2'b00, op});
    if (n != 8'h00)
      rc("cycles", 8'h0C, {24'h0, n});
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rc("sp_reset", 8'h08, 32'h0FFF, 32'hFFFF);
    rc("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, 8'h04, 32'hA5);
    gr(5, 8'h5A);
    gr(6, 8'h6B);
    gr(7, 8'h7C);
    gr(30, 8'h10);
    gr(28, 8'h20);
    ex(OP_IND_WR_INC, 5, 0, 0, 1);
    chk("st_inc", 8'h5A, mdl.mem[8'h10]);
    rg("z_inc", 30, 8'h11);
    ex(OP_IND_WR_DEC, 6, 0, 0, 1);
    chk("st_dec", 8'h6B, mdl.mem[8'h10]);
    rg("z_dec", 30, 8'h10);
    ex(OP_DISP_WR_Y, 7, 0, 6'h05, 1);
    chk("st_y", 8'h7C, mdl.mem[8'h25]);
    ex(OP_IND_WR, 7, 0, 0, 1);
    chk("st_z", 8'h7C, mdl.mem[8'h10]);
    gr(31, 8'h40);
    ex(OP_DISP_WR_Z, 5, 0, 6'h03, 0);
    rc("nvm_slow", 8'h0C, 32'h2);
    stall <= 4'h3;
    ex(OP_IND_WR, 6, 0, 0, 0);
    rc("nvm_stall", 8'h0C, 32'h4);
    chk("st_nvm", 8'h6B, mdl.mem[8'h10]);
    stall <= 4'h0;
    gr(31, 8'h00);
    gr(30, 8'h07);
    ex(OP_PMR_DEF, 9, 0, 0, 3);
    rg("pm_r0", 0, 8'hFC);
    gr(30, 8'h06);
    ex(OP_PMR_INC, 9, 0, 0, 3);
    rg("pm_lo", 9, 8'h03);
    ex(OP_PMR, 10, 0, 0, 3);
    rg("pm_hi", 10, 8'hFC);
    ex(OP_IO_RD, 11, 0, 6'h12, 1);
    rg("io_in", 11, 8'h2E);
    ex(OP_IO_WR, 7, 0, 6'h21, 1);
    chk("io_out", {3'b100, 6'h21, 8'h7C}, io_log);
    ex(OP_IO_SET, 0, 5, 6'h07, 1);
    chk("io_set", {3'b010, 6'h07, 8'h20}, io_log);
    ex(OP_IO_CLR, 0, 2, 6'h07, 1);
    chk("io_clr", {3'b001, 6'h07, 8'h04}, io_log);
    ex(OP_PUSH, 5, 0, 0, 1);
    chk("push", 8'h5A, mdl.mem[8'hFF]);
    ex(OP_POP, 12, 0, 0, 2);
    rg("pop", 12, 8'h5A);
    rc("sp_back", 8'h08, 32'h0FFF, 32'hFFFF);
    rc("flags_kept", 8'h04, 32'hA5);
    for (int i = 0; i < 5; i++)
    begin
      gr(3, 8'h81);
      bus(1'b1, 8'h04, 32'h21);
      ex(sh_op[i], 3, 0, 0, 1);
      rg("shift", 3, sh_res[i]);
      rc("shift_flags", 8'h04, {24'h0, sh_flg[i]});
    end
    bus(1'b1, 8'h04, 32'h0);
    ex(OP_T_CAPTURE, 12, 4, 0, 1);
    rc("t_cap", 8'h04, 32'h40);
    ex(OP_T_DEPOSIT, 13, 2, 0, 1);
    rg("t_dep", 13, 8'h04);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h04, 32'h0);
      ex(OP_FLAG_SET, 0, 3'(i), 0, 1);
      rc("flag_set", 8'h04, 32'h1 << i);
      bus(1'b1, 8'h04, 32'hFF);
      ex(OP_FLAG_CLR, 0, 3'(i), 0, 1);
      rc("flag_clr", 8'h04, 32'hFF ^ (32'h1 << i));
    end
    for (int i = 0; i < 4; i++)
    begin
      ex(ct_op[i], 0, 0, 0, 1);
      chk("ctl_pulse", {29'h0, ct_exp[i]}, {29'h0, ctl_log});
    end
    rc("ctl_flags", 8'h04, 32'h7F);
    finish_test();
  end
endmodule
`default_nettype wire

// ---- verif/csf_mem_model.sv ----
// data memory and program memory facing csf_core
// assumes the core's memory ports on the same clock
`timescale 1ns/1ns
`default_nettype none
module csf_mem_model
(
  input wire logic core_clk,
  input wire logic dm_req,
  input wire logic dm_we,
  input wire logic [15:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata,
  output logic dm_ready,
  input wire logic [14:0] pm_addr,
  output logic [15:0] pm_rdata,
  input wire logic [3:0] stall
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_cnt = 4'h0;
  // nonvolatile window held off like a busy controller
  assign dm_ready = dm_req && wait_cnt >= (dm_addr >= 16'h4000 ? stall : 4'h0);
  // idle reads show the inverse so a stale sample fails
  assign dm_rdata = (dm_req && !dm_we) ? mem[dm_addr[7:0]] : ~mem[dm_addr[7:0]];
  assign pm_rdata = {~pm_addr[7:0], pm_addr[7:0]};
  // grant counting and write capture
  always @(posedge core_clk)
  begin
    wait_cnt <= (dm_req && !dm_ready) ? wait_cnt + 4'h1 : 4'h0;
    if (dm_req && dm_ready && dm_we)
      mem[dm_addr[7:0]] <= dm_wdata;
  end
endmodule
`default_nettype wire
